// File: design/irkp_carrier_gen.sv
`timescale 1ns/100ps
`include "irkp_params.svh"
module irkp_carrier_gen
    import irkp_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst_n,
    irkp_carrier_if.gen car
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic       phase_reg;
    logic       phase_next;
    logic       active_reg;
    logic [3:0] half;
    logic       wrap;
    logic       undivided;

    function automatic logic [3:0] half_of(irkp_car_sel_t s);
        unique case (s)
            IRKP_CAR_DIV2:  half_of = `IRKP_HALF_DIV2;
            IRKP_CAR_DIV8:  half_of = `IRKP_HALF_DIV8;
            IRKP_CAR_DIV12: half_of = `IRKP_HALF_DIV12;
            IRKP_CAR_DIV16: half_of = `IRKP_HALF_DIV16;
            IRKP_CAR_DIV24: half_of = `IRKP_HALF_DIV24;
            default:        half_of = `IRKP_HALF_DIV2;
        endcase
    endfunction

    assign half       = half_of(car.sel);
    // A switch to a shorter division never leaves the count stranded above its end
    assign wrap       = (cnt_reg >= half - 4'h1);
    assign undivided  = (car.sel == IRKP_CAR_DIV1);
    // Count runs with the active flag so the first high half period is full length
    assign cnt_next   = (!active_reg || wrap) ? 4'h0 : cnt_reg + 4'h1;
    // Carrier starts with a high half period when transmission begins
    assign phase_next = !active_reg ? 1'b1
                      : (car.sel == IRKP_CAR_HIGH) ? 1'b1
                      : wrap ? ~phase_reg : phase_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg    <= 4'h0;
            phase_reg  <= 1'b1;
            active_reg <= 1'b0;
        end
        else
        begin
            cnt_reg    <= cnt_next;
            phase_reg  <= phase_next;
            active_reg <= car.tx_en;
        end
    end

    // Undivided carrier is the oscillator itself, gated by the active flag
    assign car.carrier   = active_reg & (undivided ? clk : phase_reg);
    assign car.tx_active = active_reg;

    div_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
        (car.tx_en && $past(car.tx_en) && car.sel == IRKP_CAR_DIV2
         && $past(car.sel) == IRKP_CAR_DIV2) |=> (phase_reg != $past(phase_reg)))
        else $error("divide-by-2 carrier did not toggle");
    high_level_a: assert property (@(posedge clk) disable iff (!rst_n)
        (car.tx_en && car.sel == IRKP_CAR_HIGH) |=> phase_reg)
        else $error("no-carrier selection did not give a steady high");
endmodule

// File: design/irkp_carrier_if.sv
`timescale 1ns/100ps
interface irkp_carrier_if;
    import irkp_pkg::*;
    irkp_car_sel_t sel;
    logic          tx_en;
    logic          carrier;
    logic          tx_active;
    modport gen  (input sel, input tx_en, output carrier, output tx_active);
    modport user (output sel, output tx_en, input carrier, input tx_active);
endinterface

// File: design/irkp_params.svh
`ifndef IRKP_PARAMS_SVH
`define IRKP_PARAMS_SVH

// Reset values of the control state
`define IRKP_SCAN_OUT_MODE_RST  1'b1
`define IRKP_SCAN_DATA_RST      8'hff
`define IRKP_SENSE_A_IN_RST     1'b0
`define IRKP_SENSE_B_OUT_RST    1'b1
`define IRKP_SENSE_PD_RST       1'b0
`define IRKP_KEY_RET_PD_RST     1'b1

// Synchroniser vector layout and reset value (reset pin idles high)
`define IRKP_SYNC_W             17
`define IRKP_SYNC_RST           17'h10000
`define IRKP_SYNC_RESET_PIN     16
`define IRKP_SYNC_POC_REQ       15
`define IRKP_SYNC_POC_FITTED    14
`define IRKP_SYNC_SENSE_A       13
`define IRKP_SYNC_SENSE_B       12
`define IRKP_SYNC_KEY_RET_HI    11
`define IRKP_SYNC_KEY_RET_LO    8
`define IRKP_SYNC_SCAN_HI       7
`define IRKP_SYNC_SCAN_LO       0

// Half periods of the divided carriers, in oscillator cycles
`define IRKP_HALF_DIV2          4'h1
`define IRKP_HALF_DIV8          4'h4
`define IRKP_HALF_DIV12         4'h6
`define IRKP_HALF_DIV16         4'h8
`define IRKP_HALF_DIV24         4'hc

`endif

// File: design/irkp_pin_logic.sv
// Operation
// - The eight key-scan pins change direction together from one mode bit.
// - In input mode every key-scan pin has its pull-down connected.
// - In output mode the key-scan pins drive push-pull, high after reset.
// - One setting enables the pull-downs of both sense inputs in input mode.
// - Sense input A leaving input mode goes to an off, high-impedance state, also at reset.
// - Sense pin B in output mode is an active-low push-pull indicator, high after reset.
// - The indicator drives low in step with carrier transmission.
// - The infrared output is active-high push-pull and low during reset.
// - The carrier is undivided, divided by 2, 8, 12, 16, 24, or steady high.
// - A low reset pin resets the processor; the pin idles high via a pull-up.
// - A power-on clear, when fitted, drives the reset pin low itself.
// - One setting controls all four key-return pull-downs; they read low after reset.
`timescale 1ns/100ps
`include "irkp_params.svh"
module irkp_pin_logic
    import irkp_pkg::*;
(
    input  wire logic                SYS_CLK,
    input  wire logic                RST_N,
    // Control port from the processor
    input  wire logic                CTRL_WR,
    input  wire logic                SCAN_OUT_MODE,
    input  wire logic [7:0]          SCAN_WR_DATA,
    input  wire logic                SENSE_A_IN_MODE,
    input  wire logic                SENSE_B_OUT_MODE,
    input  wire logic                SENSE_PD_SEL,
    input  wire logic                KEY_RET_PD_SEL,
    input  wire irkp_car_sel_t       CARRIER_SEL,
    input  wire logic                TX_ENABLE,
    output logic [7:0]               SCAN_RD_DATA,
    output logic [3:0]               KEY_RET_RD_DATA,
    output logic [1:0]               SENSE_RD_DATA,
    output logic                     CPU_RESET_N,
    // Key-scan port
    input  wire logic [7:0]          KEY_SCAN_IO_IN,
    output logic [7:0]               KEY_SCAN_IO_OUT,
    output logic                     KEY_SCAN_IO_OE_N,
    output logic                     KEY_SCAN_IO_PD_EN,
    // Key-return port
    input  wire logic [3:0]          KEY_RETURN_IN,
    output logic                     KEY_RETURN_PD_EN,
    // Sense pins
    input  wire logic                SENSE_IN_A,
    output logic                     SENSE_IN_A_PD_EN,
    input  wire logic                SENSE_IN_B_INDICATOR_IN,
    output logic                     SENSE_IN_B_INDICATOR_OUT,
    output logic                     SENSE_IN_B_INDICATOR_OE_N,
    output logic                     SENSE_IN_B_PD_EN,
    // Infrared output
    output logic                     IR_CARRIER_OUT,
    // Reset pin and power-on clear
    input  wire logic                RESET_PIN_IN,
    output logic                     RESET_PIN_OUT,
    output logic                     RESET_PIN_OE_N,
    input  wire logic                POWER_ON_CLEAR_REQ,
    input  wire logic                POWER_ON_CLEAR_FITTED
);
    logic                    scan_out_reg;
    logic [7:0]              scan_data_reg;
    logic                    sense_a_in_reg;
    logic                    sense_b_out_reg;
    logic                    sense_pd_reg;
    logic                    key_ret_pd_reg;
    irkp_car_sel_t           car_sel_reg;
    logic                    tx_en_reg;
    logic [`IRKP_SYNC_W-1:0] meta_reg;
    logic [`IRKP_SYNC_W-1:0] sync_reg;
    logic [7:0]              scan_rd_reg;
    logic [3:0]              key_ret_rd_reg;
    logic [1:0]              sense_rd_reg;
    logic                    cpu_rst_n_reg;
    logic                    indicator_n_reg;
    logic [`IRKP_SYNC_W-1:0] pins_raw;
    logic [7:0]              scan_pins;
    logic [3:0]              key_ret_pins;
    logic                    poc_drive;
    logic                    sys_reset_req;
    logic [7:0]              scan_rd_next;
    logic [1:0]              sense_rd_next;

    irkp_carrier_if car ();

    irkp_carrier_gen u_carrier_gen
    (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .car   (car.gen)
    );

    // Control state; software is expected to rewrite it on every loop pass
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            scan_out_reg    <= `IRKP_SCAN_OUT_MODE_RST;
            scan_data_reg   <= `IRKP_SCAN_DATA_RST;
            sense_a_in_reg  <= `IRKP_SENSE_A_IN_RST;
            sense_b_out_reg <= `IRKP_SENSE_B_OUT_RST;
            sense_pd_reg    <= `IRKP_SENSE_PD_RST;
            key_ret_pd_reg  <= `IRKP_KEY_RET_PD_RST;
            car_sel_reg     <= IRKP_CAR_HIGH;
            tx_en_reg       <= 1'b0;
        end
        else if (CTRL_WR)
        begin
            scan_out_reg    <= SCAN_OUT_MODE;
            scan_data_reg   <= SCAN_WR_DATA;
            sense_a_in_reg  <= SENSE_A_IN_MODE;
            sense_b_out_reg <= SENSE_B_OUT_MODE;
            sense_pd_reg    <= SENSE_PD_SEL;
            key_ret_pd_reg  <= KEY_RET_PD_SEL;
            car_sel_reg     <= CARRIER_SEL;
            tx_en_reg       <= TX_ENABLE;
        end
    end

    // Two-stage synchroniser for every pin input
    assign pins_raw = {RESET_PIN_IN, POWER_ON_CLEAR_REQ, POWER_ON_CLEAR_FITTED,
                       SENSE_IN_A, SENSE_IN_B_INDICATOR_IN, KEY_RETURN_IN, KEY_SCAN_IO_IN};

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            meta_reg <= `IRKP_SYNC_RST;
            sync_reg <= `IRKP_SYNC_RST;
        end
        else
        begin
            meta_reg <= pins_raw;
            sync_reg <= meta_reg;
        end
    end

    assign scan_pins    = sync_reg[`IRKP_SYNC_SCAN_HI:`IRKP_SYNC_SCAN_LO];
    assign key_ret_pins = sync_reg[`IRKP_SYNC_KEY_RET_HI:`IRKP_SYNC_KEY_RET_LO];

    // Power-on clear pulls the reset pin down only when the circuit is fitted
    assign poc_drive     = sync_reg[`IRKP_SYNC_POC_FITTED]
                         & sync_reg[`IRKP_SYNC_POC_REQ];
    assign sys_reset_req = ~sync_reg[`IRKP_SYNC_RESET_PIN] | poc_drive;

    // Read-back: output latch in output mode, pins otherwise; an off pin reads low
    assign scan_rd_next  = scan_out_reg ? scan_data_reg : scan_pins;
    assign sense_rd_next = {sense_b_out_reg ? indicator_n_reg : sync_reg[`IRKP_SYNC_SENSE_B],
                            sense_a_in_reg & sync_reg[`IRKP_SYNC_SENSE_A]};

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            scan_rd_reg     <= `IRKP_SCAN_DATA_RST;
            key_ret_rd_reg  <= 4'h0;
            sense_rd_reg    <= 2'h0;
            cpu_rst_n_reg   <= 1'b0;
            indicator_n_reg <= 1'b1;
        end
        else
        begin
            scan_rd_reg     <= scan_rd_next;
            key_ret_rd_reg  <= key_ret_pins;
            sense_rd_reg    <= sense_rd_next;
            cpu_rst_n_reg   <= ~sys_reset_req;
            indicator_n_reg <= ~car.tx_en;
        end
    end

    assign car.sel   = car_sel_reg;
    assign car.tx_en = tx_en_reg;

    assign SCAN_RD_DATA    = scan_rd_reg;
    assign KEY_RET_RD_DATA = key_ret_rd_reg;
    assign SENSE_RD_DATA   = sense_rd_reg;
    assign CPU_RESET_N     = cpu_rst_n_reg;

    assign KEY_SCAN_IO_OUT   = scan_data_reg;
    assign KEY_SCAN_IO_OE_N  = ~scan_out_reg;
    assign KEY_SCAN_IO_PD_EN = ~scan_out_reg;

    assign KEY_RETURN_PD_EN = key_ret_pd_reg;

    // Sense A has no output driver; off mode only drops the pull-down
    assign SENSE_IN_A_PD_EN = sense_a_in_reg & sense_pd_reg;

    assign SENSE_IN_B_INDICATOR_OUT  = indicator_n_reg;
    assign SENSE_IN_B_INDICATOR_OE_N = ~sense_b_out_reg;
    assign SENSE_IN_B_PD_EN          = ~sense_b_out_reg & sense_pd_reg;

    assign IR_CARRIER_OUT = car.carrier;

    assign RESET_PIN_OUT  = 1'b0;
    assign RESET_PIN_OE_N = ~poc_drive;

    scan_group_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (CTRL_WR && SCAN_OUT_MODE) |=> (!KEY_SCAN_IO_OE_N && !KEY_SCAN_IO_PD_EN))
        else $error("key-scan group did not turn to output");
    scan_pull_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (CTRL_WR && !SCAN_OUT_MODE) |=> (KEY_SCAN_IO_OE_N && KEY_SCAN_IO_PD_EN))
        else $error("key-scan input mode without pull-down");
    scan_drive_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (CTRL_WR && SCAN_OUT_MODE) |=> (KEY_SCAN_IO_OUT == $past(SCAN_WR_DATA)))
        else $error("key-scan output level not driven");
    sense_pull_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (CTRL_WR && SENSE_A_IN_MODE && !SENSE_B_OUT_MODE)
        |=> (SENSE_IN_A_PD_EN == $past(SENSE_PD_SEL)
             && SENSE_IN_B_PD_EN == $past(SENSE_PD_SEL)))
        else $error("sense pull-downs not switched together");
    sense_off_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (CTRL_WR && !SENSE_A_IN_MODE) |=> (!SENSE_IN_A_PD_EN) ##2 (SENSE_RD_DATA[0] == 1'b0))
        else $error("sense A off mode not high impedance");
    led_sync_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        car.tx_active |-> (SENSE_IN_B_INDICATOR_OUT == 1'b0))
        else $error("indicator not low during transmission");
    ir_idle_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (!tx_en_reg ##1 !tx_en_reg) |-> (!IR_CARRIER_OUT && SENSE_IN_B_INDICATOR_OUT))
        else $error("output active without transmission");
    poc_drive_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (POWER_ON_CLEAR_FITTED && POWER_ON_CLEAR_REQ)[*3] |-> !RESET_PIN_OE_N)
        else $error("power-on clear did not drive the reset pin");
    cpu_reset_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (!RESET_PIN_IN)[*4] |-> !CPU_RESET_N)
        else $error("reset pin low did not reset the processor");

    tx_burst_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        car.tx_active ##1 IR_CARRIER_OUT ##1 !IR_CARRIER_OUT);
    scan_input_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        KEY_SCAN_IO_OE_N ##1 !KEY_SCAN_IO_OE_N);
    poc_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N) !RESET_PIN_OE_N);
endmodule

// File: design/irkp_pkg.sv
package irkp_pkg;
    typedef enum logic [2:0]
    {
        IRKP_CAR_DIV1  = 3'b000,
        IRKP_CAR_DIV8  = 3'b001,
        IRKP_CAR_DIV12 = 3'b010,
        IRKP_CAR_HIGH  = 3'b011,
        IRKP_CAR_DIV2  = 3'b100,
        IRKP_CAR_DIV16 = 3'b101,
        IRKP_CAR_DIV24 = 3'b110
    } irkp_car_sel_t;
endpackage

// File: tb/irkp_key_matrix.sv
`timescale 1ns/100ps
module irkp_key_matrix (
    input  wire logic        sys_clk,
    input  wire logic [7:0]  scan_out,
    input  wire logic        scan_oe_n,
    input  wire logic        scan_pd_en,
    input  wire logic        kr_pd_en,
    input  wire logic        sa_pd_en,
    input  wire logic        sb_out,
    input  wire logic        sb_oe_n,
    input  wire logic        sb_pd_en,
    input  wire logic        rst_oe_n,
    input  wire logic        rst_out,
    input  wire logic        ir_out,
    input  wire logic [31:0] key_map,
    input  wire logic [7:0]  ext_scan,
    input  wire logic        ext_scan_en,
    input  wire logic [1:0]  ext_sense,
    input  wire logic        ext_sense_en,
    input  wire logic        ext_rst_low,
    input  wire logic        ir_clr,
    output logic [7:0]       scan_pin,
    output logic [3:0]       kr_pin,
    output logic             sa_pin,
    output logic             sb_pin,
    output logic             rst_pin,
    output logic [15:0]      ir_cnt
);
    logic       flt_reg = 1'b0;
    logic [3:0] kr_drv;
    // Released lines without a pull toggle, so a stale level never reads back
    always_ff @(posedge sys_clk) flt_reg <= ~flt_reg;
    assign scan_pin = !scan_oe_n ? scan_out : ext_scan_en ? ext_scan :
                      scan_pd_en ? 8'h00 : {8{flt_reg}};
    // A pressed key ties scan line i to return line j (bit i*4+j)
    always_comb
    begin
        kr_drv = 4'h0;
        for (int i = 0; i < 8; i++) kr_drv |= key_map[i*4+:4] & {4{scan_pin[i]}};
    end
    assign kr_pin = kr_drv | (kr_pd_en ? 4'h0 : {4{flt_reg}});
    assign sa_pin = ext_sense_en ? ext_sense[0] : sa_pd_en ? 1'b0 : flt_reg;
    assign sb_pin = !sb_oe_n ? sb_out : ext_sense_en ? ext_sense[1] :
                    sb_pd_en ? 1'b0 : flt_reg;
    assign rst_pin = !rst_oe_n ? rst_out : !ext_rst_low;
    // Infrared driver side: counts carrier pulses
    always_ff @(posedge ir_out or posedge ir_clr)
        if (ir_clr) ir_cnt <= 16'h0000;
        else ir_cnt <= ir_cnt + 16'h0001;
endmodule

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import irkp_pkg::*;
    typedef struct packed
    {
        logic [12:0] ctl;
        logic [5:0]  pins;
        logic [7:0]  out;
        logic [7:0]  rd;
    } irkp_row_t;
    logic          sys_clk, rst_n, ctrl_wr, som, sam, sbo, spd, kpd, tx, poc_req, poc_fit;
    logic [7:0]    sd, scan_rd, scan_out, scan_pin, ext_scan;
    irkp_car_sel_t cs;
    logic [3:0]    kr_rd, kr_pin;
    logic [1:0]    sense_rd, ext_sense;
    logic          cpu_n, scan_oe_n, scan_pd, kr_pd, sa_pd, sb_out, sb_oe_n, sb_pd, ir;
    logic          rst_oe_n, sa_pin, sb_pin, rst_pin, ext_scan_en, ext_sense_en;
    logic          ext_rst_low, ir_clr, rst_out;
    logic [31:0]   key_map;
    logic [15:0]   ir_cnt;
    int            n_mismatch, cmp_count;
    irkp_row_t rows [5] = '{
        '{{1'b1, 8'ha5, 4'h5}, 6'h01, 8'ha5, 8'ha5},
        '{{1'b0, 8'h3c, 4'ha}, 6'h3e, 8'h00, 8'h00},
        '{{1'b1, 8'h00, 4'hf}, 6'h09, 8'h00, 8'h00},
        '{{1'b1, 8'hff, 4'h3}, 6'h07, 8'hff, 8'hff},
        '{{1'b0, 8'h00, 4'h9}, 6'h35, 8'h00, 8'h00}};
    irkp_car_sel_t car_sel [7] = '{IRKP_CAR_DIV1, IRKP_CAR_DIV2, IRKP_CAR_DIV8,
        IRKP_CAR_DIV12, IRKP_CAR_DIV16, IRKP_CAR_DIV24, IRKP_CAR_HIGH};
    // Carrier pulses in a 240-cycle window
    logic [15:0] car_edges [7] = '{16'h00f0, 16'h0078, 16'h001e, 16'h0014, 16'h000f,
        16'h000a, 16'h0000};

    irkp_pin_logic irkp_pin_logic_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .CTRL_WR(ctrl_wr),
        .SCAN_OUT_MODE(som), .SCAN_WR_DATA(sd), .SENSE_A_IN_MODE(sam), .SENSE_B_OUT_MODE(sbo),
        .SENSE_PD_SEL(spd), .KEY_RET_PD_SEL(kpd), .CARRIER_SEL(cs), .TX_ENABLE(tx),
        .SCAN_RD_DATA(scan_rd), .KEY_RET_RD_DATA(kr_rd), .SENSE_RD_DATA(sense_rd),
        .CPU_RESET_N(cpu_n), .KEY_SCAN_IO_IN(scan_pin), .KEY_SCAN_IO_OUT(scan_out),
        .KEY_SCAN_IO_OE_N(scan_oe_n), .KEY_SCAN_IO_PD_EN(scan_pd), .KEY_RETURN_IN(kr_pin),
        .KEY_RETURN_PD_EN(kr_pd), .SENSE_IN_A(sa_pin), .SENSE_IN_A_PD_EN(sa_pd),
        .SENSE_IN_B_INDICATOR_IN(sb_pin), .SENSE_IN_B_INDICATOR_OUT(sb_out),
        .SENSE_IN_B_INDICATOR_OE_N(sb_oe_n), .SENSE_IN_B_PD_EN(sb_pd), .IR_CARRIER_OUT(ir),
        .RESET_PIN_IN(rst_pin), .RESET_PIN_OUT(rst_out), .RESET_PIN_OE_N(rst_oe_n),
        .POWER_ON_CLEAR_REQ(poc_req), .POWER_ON_CLEAR_FITTED(poc_fit));
    irkp_key_matrix irkp_key_matrix_inst (.sys_clk(sys_clk), .scan_out(scan_out),
        .scan_oe_n(scan_oe_n), .scan_pd_en(scan_pd), .kr_pd_en(kr_pd), .sa_pd_en(sa_pd),
        .sb_out(sb_out), .sb_oe_n(sb_oe_n), .sb_pd_en(sb_pd), .rst_oe_n(rst_oe_n),
        .rst_out(rst_out),
        .ir_out(ir), .key_map(key_map), .ext_scan(ext_scan), .ext_scan_en(ext_scan_en),
        .ext_sense(ext_sense), .ext_sense_en(ext_sense_en), .ext_rst_low(ext_rst_low),
        .ir_clr(ir_clr), .scan_pin(scan_pin), .kr_pin(kr_pin), .sa_pin(sa_pin),
        .sb_pin(sb_pin), .rst_pin(rst_pin), .ir_cnt(ir_cnt));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One control write; returns at a falling edge once outputs have settled
    task automatic wr(input logic [12:0] c, input irkp_car_sel_t s, input logic t);
        @(posedge sys_clk);
        ctrl_wr <= 1'b1;
        {som, sd, sam, sbo, spd, kpd} <= c;
        cs <= s;
        tx <= t;
        @(posedge sys_clk);
        ctrl_wr <= 1'b0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({scan_oe_n, scan_out, scan_pd, sa_pd}, {1'b0, 8'hff, 2'h0});
        chk({sb_oe_n, sb_out, sb_pd, ir}, 4'h4);
        chk({kr_pd, cpu_n, rst_oe_n}, 3'h5);
        key_map = 32'h0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({kr_rd, cpu_n}, 5'h01);
    endtask

    task automatic wait_cpu(input logic v);
        for (int i = 0; i < 20 && cpu_n !== v; i++) @(negedge sys_clk);
        if (cpu_n !== v)
        begin
            n_mismatch++;
            report_and_stop();
        end
    endtask

    initial
    begin
        {rst_n, ctrl_wr, som, sam, sbo, spd, kpd, tx, poc_req, poc_fit} = 10'h0;
        {sd, ext_scan, ext_sense, ext_scan_en, ext_sense_en, ext_rst_low, ir_clr} = 22'h0;
        cs = IRKP_CAR_HIGH;
        key_map = 32'h0;
        do_reset();
        foreach (rows[i])
        begin
            wr(rows[i].ctl, IRKP_CAR_HIGH, 1'b0);
            chk({scan_oe_n, scan_pd, sa_pd, sb_oe_n, sb_pd, kr_pd}, rows[i].pins);
            if (!rows[i].pins[5]) chk(scan_out, rows[i].out);
            chk(scan_rd, rows[i].rd);
            chk(ir, 1'b0);
        end
        key_map = 32'h0000_0200;
        wr({1'b1, 8'h04, 4'h5}, IRKP_CAR_HIGH, 1'b0);
        chk(kr_rd, 4'h2);
        wr({1'b1, 8'hfb, 4'h5}, IRKP_CAR_HIGH, 1'b0);
        chk(kr_rd, 4'h0);
        key_map = 32'h0;
        {ext_scan, ext_sense, ext_scan_en, ext_sense_en} = 12'h5af;
        wr({1'b0, 8'h00, 4'ha}, IRKP_CAR_HIGH, 1'b0);
        chk({scan_rd, sense_rd}, {8'h5a, 2'h3});
        wr({1'b0, 8'h00, 4'h2}, IRKP_CAR_HIGH, 1'b0);
        chk(sense_rd, 2'h2);
        {ext_scan_en, ext_sense_en} = 2'h0;
        for (int k = 0; k < 7; k++)
        begin
            wr({1'b1, 8'hff, 4'h5}, car_sel[k], 1'b1);
            ir_clr = 1'b1;
            #1 ir_clr = 1'b0;
            repeat (240) @(negedge sys_clk);
            chk(ir_cnt, car_edges[k]);
            chk({sb_out, sb_pin}, 2'h0);
            if (car_sel[k] == IRKP_CAR_HIGH) chk(ir, 1'b1);
        end
        wr({1'b1, 8'hff, 4'h5}, IRKP_CAR_DIV8, 1'b0);
        chk({ir, sb_out}, 2'h1);
        // Reset in mid-transmission must silence the carrier
        wr({1'b1, 8'hff, 4'h5}, IRKP_CAR_DIV8, 1'b1);
        do_reset();
        ext_rst_low = 1'b1;
        wait_cpu(1'b0);
        chk(cpu_n, 1'b0);
        ext_rst_low = 1'b0;
        wait_cpu(1'b1);
        chk(cpu_n, 1'b1);
        @(posedge sys_clk);
        poc_req <= 1'b1;
        repeat (6) @(negedge sys_clk);
        chk({rst_oe_n, cpu_n}, 2'h3);
        @(posedge sys_clk);
        poc_fit <= 1'b1;
        wait_cpu(1'b0);
        chk({rst_oe_n, rst_pin, cpu_n}, 3'h0);
        @(posedge sys_clk);
        poc_req <= 1'b0;
        wait_cpu(1'b1);
        chk({rst_oe_n, cpu_n}, 2'h3);
        report_and_stop();
    end

    initial
    begin
        #1000000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
